/* hw/cbpd_pkg.sv */
// shared constants and types for the clock buffer power-down block
`default_nettype none
package cbpd_pkg;
   localparam logic [7:0] REG_IDENT_OFS    = 8'h05;
   localparam logic [7:0] REG_RBLEN_OFS    = 8'h06;
   localparam logic [7:0] RBLEN_RESET      = 8'h07;
   localparam logic [7:0] IDENT_CODE_DFLT  = 8'h5a; // arbitrary neutral value
   localparam int         MCLK_HZ          = 50_000_000;
   localparam int         RELEASE_US       = 300;
   localparam int         LOCK_US          = 1000;
   // longest times round down
   localparam int         RELEASE_CYC      = (RELEASE_US * (MCLK_HZ / 1_000_000));
   localparam int         LOCK_CYC         = (LOCK_US * (MCLK_HZ / 1_000_000)) - 1;
   localparam int         NUM_OUT          = 4;
   // register port request
   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cbpd_req_t;
   // one output pair drive: level and enables
   typedef struct packed
   {
      logic tru;
      logic tru_oe;
      logic cmp;
      logic cmp_oe;
   } cbpd_pair_t;
endpackage
`default_nettype wire

/* hw/cbpd_top.sv */
// power-down sequencing and management registers of the clock buffer
`default_nettype none
// Contract
// - readback length register writable, sets block length
// - power-down stops all outputs cleanly
// - power-down input asynchronous, active low
// - park outputs before PLL turns off
// - qualify low on two complement rising edges
// - freeze pairs at next complement falling edge
// - mode 0: true driven high, comp tri-stated
// - mode 1: both outputs tri-stated
// - locked clocks within 1 ms of release
// - mode 1: drive outputs within 300 us
// - pair runs only with enable bit and pin
// - block read: count byte then that many bytes
module cbpd_top #(
   parameter int          NOUT       = cbpd_pkg::NUM_OUT,
   parameter int          LOCK_CYC   = cbpd_pkg::LOCK_CYC,
   parameter int          REL_CYC    = cbpd_pkg::RELEASE_CYC,
   parameter logic [7:0]  IDENT_CODE = cbpd_pkg::IDENT_CODE_DFLT
) (
   input  wire logic                    mclk,
   input  wire logic                    rst_b,
   input  wire logic                    clk_link,
   input  wire logic                    power_down_n,
   input  wire logic                    power_down_tristate_sel,
   input  wire logic [NOUT-1:0]         out_en_bits,
   input  wire logic [NOUT-1:0]         out_en_pin_n,
   input  wire cbpd_pkg::cbpd_req_t     req,
   input  wire logic                    blk_start,
   input  wire logic                    blk_next,
   output logic [7:0]                   rdata,
   output logic                         rvalid,
   output logic                         blk_last,
   output logic                         pll_on,
   output logic                         pll_locked,
   output cbpd_pkg::cbpd_pair_t [NOUT-1:0] pairs
);
   // refuse sizes that the pair vector and the timers cannot serve
   if (NOUT < 1 || NOUT > 8 || LOCK_CYC < 1 || REL_CYC < 1)
   begin : g_bad_param
      $error("cbpd_top: unsupported parameters");
   end

   // register state (mclk)
   logic [7:0] rblen;
   logic [7:0] next_rblen;
   logic [7:0] blk_cnt;
   logic [7:0] next_blk_cnt;
   logic       blk_act;
   logic       next_blk_act;
   logic [7:0] next_rdata;
   logic       next_rvalid;
   logic       next_blk_last;

   function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] len);
      logic [7:0] v;
      v = 8'h00;
      if (a == cbpd_pkg::REG_IDENT_OFS)
         v = IDENT_CODE;
      else if (a == cbpd_pkg::REG_RBLEN_OFS)
         v = len;
      return v;
   endfunction

   // register access and block read sequencing
   always_comb
   begin
      next_rblen    = rblen;
      next_rdata    = rdata;
      next_rvalid   = 1'b0;
      next_blk_cnt  = blk_cnt;
      next_blk_act  = blk_act;
      next_blk_last = 1'b0;
      // only the length register takes writes
      if (req.wr && req.addr == cbpd_pkg::REG_RBLEN_OFS)
         next_rblen = req.wdata;
      if (req.rd)
      begin
         next_rdata  = reg_read(req.addr, rblen);
         next_rvalid = 1'b1;
      end
      // count byte first, then rblen bytes
      if (blk_start)
      begin
         next_rdata    = rblen;
         next_rvalid   = 1'b1;
         next_blk_cnt  = 8'h00;
         next_blk_act  = (rblen != 8'h00);
         next_blk_last = (rblen == 8'h00);
      end
      else if (blk_act && blk_next)
      begin
         next_rdata    = reg_read(blk_cnt, rblen);
         next_rvalid   = 1'b1;
         next_blk_cnt  = blk_cnt + 8'h01;
         next_blk_last = (blk_cnt + 8'h01 == rblen);
         next_blk_act  = (blk_cnt + 8'h01 != rblen);
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rblen    <= cbpd_pkg::RBLEN_RESET;
         rdata    <= 8'h00;
         rvalid   <= 1'b0;
         blk_cnt  <= 8'h00;
         blk_act  <= 1'b0;
         blk_last <= 1'b0;
      end
      else
      begin
         rblen    <= next_rblen;
         rdata    <= next_rdata;
         rvalid   <= next_rvalid;
         blk_cnt  <= next_blk_cnt;
         blk_act  <= next_blk_act;
         blk_last <= next_blk_last;
      end
   end

   // link domain: complement output clock (clk_link high half = comp high)
   logic       lrst_s1;
   logic       lrst_b;
   logic       pd_s1;
   logic       pd_s2;
   logic       pd_q;
   logic       next_pd_q;
   logic       pd_seen;
   logic       next_pd_seen;
   logic       frz;
   logic       mode_s1;
   logic       mode_s2;
   logic [2*NOUT-1:0] en_s1;
   logic [2*NOUT-1:0] en_s2;

   // reset release synchronised to the link clock
   always_ff @(posedge clk_link or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lrst_s1 <= 1'b0;
         lrst_b  <= 1'b0;
      end
      else
      begin
         lrst_s1 <= 1'b1;
         lrst_b  <= lrst_s1;
      end
   end

   // two-flop synchroniser on the asynchronous pin
   always_ff @(posedge clk_link or negedge lrst_b)
   begin
      if (!lrst_b)
      begin
         pd_s1   <= 1'b1;
         pd_s2   <= 1'b1;
         mode_s1 <= 1'b1;
         mode_s2 <= 1'b1;
         en_s1   <= '0;
         en_s2   <= '0;
      end
      else
      begin
         pd_s1   <= power_down_n;
         pd_s2   <= pd_s1;
         mode_s1 <= power_down_tristate_sel;
         mode_s2 <= mode_s1;
         en_s1   <= {out_en_pin_n, out_en_bits}; // pins combined only after sync
         en_s2   <= en_s1;
      end
   end

   // low on two consecutive comp rising edges
   always_comb
   begin
      next_pd_q    = pd_s2;
      next_pd_seen = ~pd_s2 & ~pd_q;
   end

   always_ff @(posedge clk_link or negedge lrst_b)
   begin
      if (!lrst_b)
      begin
         pd_q    <= 1'b1;
         pd_seen <= 1'b0;
      end
      else
      begin
         pd_q    <= next_pd_q;
         pd_seen <= next_pd_seen;
      end
   end

   // freeze changes only on the falling comp edge, no runt pulses
   always_ff @(negedge clk_link or negedge lrst_b)
   begin
      if (!lrst_b)
         frz <= 1'b0;
      else
         frz <= pd_seen;
   end

   // output pair drive, updated on falling edge alongside the freeze
   genvar g;
   generate
      for (g = 0; g < NOUT; g++)
      begin : g_pair
         cbpd_pkg::cbpd_pair_t next_pair;
         always_comb
         begin
            next_pair = '0;
            if (pd_seen)
            begin
               next_pair.tru    = 1'b1;
               next_pair.tru_oe = ~mode_s2;
            end
            else if (en_s2[g] && !en_s2[NOUT+g])
            begin
               // enable bit and pin both active
               next_pair.tru    = 1'b0;
               next_pair.tru_oe = 1'b1;
               next_pair.cmp    = 1'b1;
               next_pair.cmp_oe = 1'b1;
            end
         end
         always_ff @(negedge clk_link or negedge lrst_b)
         begin
            if (!lrst_b)
               pairs[g] <= '0;
            else
               pairs[g] <= next_pair;
         end
      end
   endgenerate

   // freeze level crosses into mclk by two flops
   logic frz_m1;
   logic frz_m2;
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         frz_m1 <= 1'b0;
         frz_m2 <= 1'b0;
      end
      else
      begin
         frz_m1 <= frz;
         frz_m2 <= frz_m1;
      end
   end

   // pll control and lock timer; pll stops only after outputs parked
   logic [31:0] lock_cnt;
   logic [31:0] next_lock_cnt;
   logic        next_pll_on;
   logic        next_pll_locked;
   always_comb
   begin
      next_pll_on     = ~frz_m2;
      next_lock_cnt   = lock_cnt;
      next_pll_locked = pll_locked;
      if (frz_m2)
      begin
         next_lock_cnt   = 32'h0;
         next_pll_locked = 1'b0;
      end
      else if (!pll_locked)
      begin
         next_lock_cnt = lock_cnt + 32'h1;
         if (lock_cnt >= 32'(((LOCK_CYC < REL_CYC) ? LOCK_CYC : REL_CYC) - 1))
            next_pll_locked = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pll_on     <= 1'b0;
         pll_locked <= 1'b0;
         lock_cnt   <= 32'h0;
      end
      else
      begin
         pll_on     <= next_pll_on;
         pll_locked <= next_pll_locked;
         lock_cnt   <= next_lock_cnt;
      end
   end

   // unlocked time since release; too long a count means a stuck lock
   logic [31:0] unlk_cnt;
   logic [31:0] next_unlk_cnt;
   always_comb
   begin
      next_unlk_cnt = 32'h0;
      if (!frz_m2 && !pll_locked)
         next_unlk_cnt = unlk_cnt + 32'h1;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         unlk_cnt <= 32'h0;
      else
         unlk_cnt <= next_unlk_cnt;
   end

   // pair 0 comp tri-stated at the falling edge after power-down qualifies
   property park_cause_p;
      @(negedge clk_link) disable iff (!lrst_b)
      pd_seen |=> (pairs[0].cmp_oe == 1'b0);
   endproperty
   park_follow_a : assert property (park_cause_p)
      else $error("outputs not parked after power-down");

   qual_two_a : assert property (@(posedge clk_link) disable iff (!lrst_b)
      $rose(pd_seen) |-> ($past(pd_s2, 1) == 1'b0 && $past(pd_s2, 2) == 1'b0))
      else $error("power-down qualified too early");

   drive_mode_a : assert property (@(negedge clk_link) disable iff (!lrst_b)
      frz |-> (pairs[0].tru_oe == ~mode_s2 || $changed(mode_s2)))
      else $error("parked drive mode wrong");

   tri_both_a : assert property (@(negedge clk_link) disable iff (!lrst_b)
      (frz && mode_s2 && $stable(mode_s2)) |-> !pairs[0].tru_oe && !pairs[0].cmp_oe)
      else $error("mode 1 not fully tri-stated");

   pll_order_a : assert property (@(posedge mclk) disable iff (!rst_b)
      $fell(pll_on) |-> frz_m2)
      else $error("pll off before park");

   lock_time_a : assert property (@(posedge mclk) disable iff (!rst_b)
      unlk_cnt <= 32'(LOCK_CYC))
      else $error("lock not reached in time");

   ident_ro_a : assert property (@(posedge mclk) disable iff (!rst_b)
      (req.rd && req.addr == cbpd_pkg::REG_IDENT_OFS && !blk_start && !blk_next)
      |=> rdata == IDENT_CODE)
      else $error("identifier value wrong");

   rblen_wr_a : assert property (@(posedge mclk) disable iff (!rst_b)
      (req.wr && req.addr == cbpd_pkg::REG_RBLEN_OFS) |=> rblen == $past(req.wdata))
      else $error("length write lost");

   blk_count_a : assert property (@(posedge mclk) disable iff (!rst_b)
      blk_start |=> rvalid && rdata == $past(rblen))
      else $error("block read count byte wrong");
endmodule
`default_nettype wire

/* verif/cbpd_link_model.sv */
// link-side stand-in: makes the complement output clock seen by the receivers
`default_nettype none
module cbpd_link_model #(
   parameter int HALF_NS = 24
) (
   output logic      clk_link,
   input  wire logic power_down_n,
   input  wire logic stop_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // free-running clock; the system only pulls it while power-down is held
   initial
   begin
      clk_link = 1'b0;
      forever
      begin
         #(HALF_NS);
         if (!(stop_req && !power_down_n))
            clk_link = ~clk_link;
      end
   end
endmodule
`default_nettype wire

/* verif/cbpd_top_tb.sv */
// self-checking bench for the power-down block and its management registers
`default_nettype none
module cbpd_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int         NOUT    = 4;
   localparam logic [7:0] ID_CODE = 8'h3c; // arbitrary value
   localparam logic [3:0] RUN     = 4'h7;
   logic                           mclk, rst_b, clk_link, power_down_n, pd_sel;
   logic                           blk_start, blk_next, stop_req, rvalid, blk_last;
   logic                           pll_on, pll_locked, last;
   logic [NOUT-1:0]                en_bits, en_pin_n;
   logic [7:0]                     rdata, d, len;
   cbpd_pkg::cbpd_req_t            req;
   cbpd_pkg::cbpd_pair_t [NOUT-1:0] pairs;
   int                             num_errors, comparisons, k;

   cbpd_top #(.LOCK_CYC(20), .REL_CYC(20), .IDENT_CODE(ID_CODE)) u_cbpd_top (
      .mclk(mclk), .rst_b(rst_b), .clk_link(clk_link), .power_down_n(power_down_n),
      .power_down_tristate_sel(pd_sel), .out_en_bits(en_bits), .out_en_pin_n(en_pin_n),
      .req(req), .blk_start(blk_start), .blk_next(blk_next), .rdata(rdata),
      .rvalid(rvalid), .blk_last(blk_last), .pll_on(pll_on), .pll_locked(pll_locked),
      .pairs(pairs));
   cbpd_link_model u_cbpd_link_model (
      .clk_link(clk_link), .power_down_n(power_down_n), .stop_req(stop_req));

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("errors=%0d comparisons=%0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // bounded wait for one read answer
   task automatic get();
      for (int i = 0; i < 4 && rvalid !== 1'b1; i++)
      begin
         @(posedge mclk);
         #1;
      end
      // a missing answer counts once; the run carries on to the verdict
      if (rvalid !== 1'b1)
         num_errors++;
      d = rdata;
      last = blk_last;
   endtask
   // one-cycle register strobe
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] wd);
      @(posedge mclk);
      req <= '{wr: w, rd: !w, addr: a, wdata: wd};
      @(posedge mclk);
      req <= '0;
      #1;
      if (!w)
         get();
   endtask
   task automatic blk(input logic first);
      @(posedge mclk);
      blk_start <= first;
      blk_next  <= !first;
      @(posedge mclk);
      blk_start <= 1'b0;
      blk_next  <= 1'b0;
      #1;
      get();
   endtask
   function automatic logic [7:0] exp_reg(input int i, input logic [7:0] l);
      return (i == 5) ? ID_CODE : ((i == 6) ? l : 8'h00);
   endfunction
   task automatic wait_lnk();
      // counted on mclk so a stalled link clock cannot hang the run
      repeat (20) @(posedge mclk);
      #1;
   endtask

   // register clock
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // main sequence
   initial
   begin
      {rst_b, pd_sel, blk_start, blk_next, stop_req} = '0;
      power_down_n = 1'b1;
      en_bits = '1;
      en_pin_n = '0;
      req = '0;
      num_errors = 0;
      comparisons = 0;
      void'($urandom(32'h3538));
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      acc(0, 8'h06, 8'h00); chk({1'b0, d}, {1'b0, cbpd_pkg::RBLEN_RESET});
      acc(1, 8'h05, 8'hff); acc(0, 8'h05, 8'h00); chk({1'b0, d}, {1'b0, ID_CODE});
      acc(0, 8'h06, 8'h00); chk({1'b0, d}, {1'b0, cbpd_pkg::RBLEN_RESET});
      len = 8'($urandom_range(1, 255));
      acc(1, 8'h06, len); acc(0, 8'h06, 8'h00); chk({1'b0, d}, {1'b0, len});
      // empty block, then one covering both mapped offsets
      for (int n = 0; n < 2; n++)
      begin
         len = n ? 8'h07 : 8'h00;
         acc(1, 8'h06, len);
         blk(1'b1); chk({last, d}, {len == 8'h00, len});
         for (k = 0; k < int'(len); k++)
         begin
            blk(1'b0); chk({last, d}, {k == int'(len) - 1, exp_reg(k, len)});
         end
      end
      // a low too short for two samples is ignored
      @(posedge mclk); power_down_n <= 1'b0;
      @(posedge mclk); power_down_n <= 1'b1;
      wait_lnk(); chk({8'h0, pll_on}, 9'h001);
      for (int m = 0; m < 2; m++)
      begin
         @(posedge mclk); pd_sel <= m[0]; power_down_n <= 1'b0;
         for (k = 0; k < 100 && pll_on !== 1'b0; k++) @(posedge mclk);
         #1; chk({8'h0, pll_on}, 9'h000);
         for (k = 0; k < NOUT; k++)
            chk({5'h0, 4'(pairs[k]) & (m ? 4'h5 : 4'hd)}, m ? 9'h000 : 9'h00c);
         @(posedge mclk); stop_req <= 1'b1;
         repeat (10) @(posedge mclk);
         stop_req <= 1'b0;
         repeat (10) @(posedge mclk);
         power_down_n <= 1'b1;
         for (k = 0; k < 60 && pll_locked !== 1'b1; k++) @(posedge mclk);
         #1; chk({8'h0, pll_locked}, 9'h001);
         wait_lnk();
         for (k = 0; k < NOUT; k++)
            chk({5'h0, 4'(pairs[k])}, {5'h0, RUN});
         @(posedge mclk); en_bits <= 4'($urandom); en_pin_n <= 4'($urandom);
         wait_lnk();
         for (k = 0; k < NOUT; k++)
            chk({8'h0, 4'(pairs[k]) == RUN}, {8'h0, en_bits[k] & !en_pin_n[k]});
         @(posedge mclk); en_bits <= '1; en_pin_n <= '0;
         wait_lnk();
      end
      close_out();
   end
endmodule
`default_nettype wire
